//--- design/analog_input_scan_control.v
// analog input scan controller: per-channel settings, ascending scan, results
// assumes: one clock, converter answers each start with one done pulse
// What this block does
// - sixteen single inputs or eight pairs, 16-bit codes
// - every channel keeps its own range setting
// - four bipolar spans with fixed code steps
// - result is one of 65,536 codes
// - code step includes about five percent over-range
// - listed channels converted in ascending number order
// - one fixed interval between consecutive channel conversions while the result buffer has room and the converter answers before the slot's last cycle
// - later request waits extra before first channel
// - pair n uses input n and n+8
// - out-of-range input saturates, never wraps
// - terminal mode per channel 0..7: paired or ground-referenced; channels 8..15 are ground-referenced
`include "analog_scan_defs.vh"
module analog_input_scan_control #(
  parameter CLK_NS = `CLK_NS,
  parameter SCAN_NS = `SCAN_NS,
  parameter GAP_NS = `GAP_NS,
  parameter SETTLE_NS = `SETTLE_NS
) (
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [`DATA_W-1:0] rdata_ff,
  output reg [`CH_W-1:0] pos_sel_ff,
  output reg [`CH_W-1:0] neg_sel_ff,
  output reg neg_to_ground_ff,
  output reg [1:0] gain_sel_ff,
  output reg conv_start_ff,
  input wire adc_done,
  input wire [`RAW_W-1:0] adc_raw,
  output reg busy_ff
);
  // least times round up to whole cycles
  localparam [`CNT_W-1:0] SCAN_CYC = (SCAN_NS + CLK_NS - 1) / CLK_NS;
  localparam [`CNT_W-1:0] GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam [`CNT_W-1:0] SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam [`CNT_W-1:0] CNT_ONE = 1;

  // one-hot sequencer states
  localparam [6:0] S_IDLE = 7'b000_0001;
  localparam [6:0] S_GAP = 7'b000_0010;
  localparam [6:0] S_SEL = 7'b000_0100;
  localparam [6:0] S_APPLY = 7'b000_1000;
  localparam [6:0] S_SETTLE = 7'b001_0000;
  localparam [6:0] S_CONV = 7'b010_0000;
  localparam [6:0] S_HOLD = 7'b100_0000;

  // lowest listed channel at or above from, NO_CHAN if none
  function [4:0] next_chan;
    input [`NUM_CH-1:0] m;
    input [4:0] from;
    integer i;
    begin
      next_chan = `NO_CHAN;
      for (i = `NUM_CH - 1; i >= 0; i = i - 1) begin
        if (m[i] && (i >= from))
          next_chan = i[4:0];
      end
    end
  endfunction

  // code step of a range in microvolts
  function [15:0] lsb_uv;
    input [1:0] rng;
    begin
      case (rng)
        `RANGE_10V: lsb_uv = `LSB_10V_UV;
        `RANGE_5V: lsb_uv = `LSB_5V_UV;
        `RANGE_2V: lsb_uv = `LSB_2V_UV;
        default: lsb_uv = `LSB_1V_UV;
      endcase
    end
  endfunction

  reg [6:0] state_ff;
  reg [`CNT_W-1:0] slot_ff;
  reg [`CNT_W-1:0] gap_ff;
  reg [`NUM_CH-1:0] list_ff;
  reg [`NUM_CH-1:0] work_ff;
  reg [`NUM_PAIRS-1:0] paired_input_mode_map_ff;
  reg [`CH_W-1:0] cur_ff;
  reg start_pend_ff;
  reg has_run_ff;
  reg clip_seen_ff;
  reg [`CODE_W-1:0] code_ff;
  reg res_clip_ff;
  reg [1:0] res_range_ff;
  reg [1:0] last_range_ff;

  wire [`CFG_W-1:0] cfg_rd;
  wire cfg_wr;
  wire [`RES_W-1:0] fifo_in;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`RES_W-1:0] fifo_out;
  wire [`FIFO_AW:0] fifo_cnt;
  wire push;
  wire pop;
  wire start_wr;
  wire clr_clip;
  wire slot_end;
  wire [4:0] nxt_ch;
  wire [4:0] first_ch;
  wire [`NUM_CH-1:0] eff_list;
  wire raw_hi;
  wire raw_lo;
  wire [`CODE_W-1:0] sat_code;

  // bus decode
  assign cfg_wr = wr_en && (addr[5:4] == `CFG_PAGE);
  assign start_wr = wr_en && (addr == `REG_CTRL) && wdata[`CTRL_START];
  assign clr_clip = wr_en && (addr == `REG_CTRL) && wdata[`CTRL_CLR_CLIP];
  assign pop = rd_en && (addr == `REG_RESULT) && fifo_out_valid;

  chan_cfg_mem #(
    .WIDTH(`CFG_W),
    .DEPTH(`NUM_CH),
    .AW(`CH_W)
  ) u_cfg (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .wr_en(cfg_wr),
    .wr_addr(addr[`CH_W-1:0]),
    .wr_data(wdata[`CFG_W-1:0]),
    .rd_addr(cur_ff),
    .rd_data_ff(cfg_rd)
  );

  // drop the negative legs of every paired channel from the list
  assign eff_list = list_ff & ~{paired_input_mode_map_ff, {`NUM_PAIRS{1'b0}}};
  // search upward only, so the list's own order never matters
  assign nxt_ch = next_chan(work_ff, {1'b0, cur_ff} + 5'h01);
  assign first_ch = next_chan(eff_list, `NO_CHAN - `NO_CHAN);

  // saturate the wide converter word instead of truncating it
  assign raw_hi = !adc_raw[`RAW_W-1] && (adc_raw[`RAW_W-2:`CODE_W-1] != 2'h0);
  assign raw_lo = adc_raw[`RAW_W-1] && (adc_raw[`RAW_W-2:`CODE_W-1] != 2'h3);
  assign sat_code = raw_hi ? `CODE_MAX : (raw_lo ? `CODE_MIN : adc_raw[`CODE_W-1:0]);

  // a channel slot lasts exactly SCAN_CYC cycles unless the buffer is full or the converter answers in the slot's last cycle or later
  assign slot_end = (slot_ff >= SCAN_CYC - CNT_ONE);
  assign push = (state_ff == S_HOLD) && slot_end;
  assign fifo_in = {res_clip_ff, res_range_ff, cur_ff, code_ff};

  sample_fifo #(
    .WIDTH(`RES_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out),
    .count(fifo_cnt)
  );

  // software-written state; a clip in the clearing cycle survives
  always @(posedge clock) begin
    if (!nrst) begin
      list_ff <= {`NUM_CH{1'b0}};
      paired_input_mode_map_ff <= {`NUM_PAIRS{1'b0}};
      clip_seen_ff <= 1'b0;
    end else if (ce) begin
      if (wr_en && (addr == `REG_SCAN_LIST))
        list_ff <= wdata[`NUM_CH-1:0];
      // only channels 0..7 can pair; the bit is ignored above them
      if (cfg_wr && !addr[`CH_W-1])
        paired_input_mode_map_ff[addr[`CH_W-2:0]] <= wdata[`CFG_PAIRED_INPUT_MODE];
      if (push && res_clip_ff)
        clip_seen_ff <= 1'b1;
      else if (clr_clip)
        clip_seen_ff <= 1'b0;
    end
  end

  // register read port, data valid the cycle after the strobe
  always @(posedge clock) begin
    if (!nrst) begin
      rdata_ff <= {`DATA_W{1'b0}};
      last_range_ff <= `RANGE_10V;
    end else if (ce) begin
      rdata_ff <= {`DATA_W{1'b0}};
      if (rd_en) begin
        case (addr)
          `REG_SCAN_LIST: rdata_ff[`NUM_CH-1:0] <= list_ff;
          `REG_STATUS: begin
            rdata_ff[`STAT_BUSY] <= busy_ff;
            rdata_ff[`STAT_AVAIL] <= fifo_out_valid;
            rdata_ff[`STAT_CLIP] <= clip_seen_ff;
            rdata_ff[`STAT_CNT_HI:`STAT_CNT_LO] <= fifo_cnt;
          end
          `REG_RESULT: begin
            // buffer storage is never reset, so data passes only when valid and an empty buffer reads zero
            if (fifo_out_valid)
              rdata_ff[`RES_CLIP:0] <= fifo_out;
            rdata_ff[`RES_VALID] <= fifo_out_valid;
          end
          `REG_LSB: rdata_ff[15:0] <= lsb_uv(last_range_ff);
          default: rdata_ff <= {`DATA_W{1'b0}};
        endcase
      end
      if (pop)
        last_range_ff <= fifo_out[`RES_RANGE_HI:`RES_RANGE_LO];
    end
  end

  // sequencer: gap, select, apply settings, settle, convert, hold to slot end
  always @(posedge clock) begin
    if (!nrst) begin
      state_ff <= S_IDLE;
      slot_ff <= {`CNT_W{1'b0}};
      gap_ff <= {`CNT_W{1'b0}};
      work_ff <= {`NUM_CH{1'b0}};
      cur_ff <= `CH_ZERO;
      start_pend_ff <= 1'b0;
      has_run_ff <= 1'b0;
      busy_ff <= 1'b0;
      pos_sel_ff <= `CH_ZERO;
      neg_sel_ff <= `CH_ZERO;
      neg_to_ground_ff <= 1'b1;
      gain_sel_ff <= `RANGE_10V;
      conv_start_ff <= 1'b0;
      code_ff <= {`CODE_W{1'b0}};
      res_clip_ff <= 1'b0;
      res_range_ff <= `RANGE_10V;
    end else if (ce) begin
      conv_start_ff <= 1'b0;
      slot_ff <= slot_ff + CNT_ONE;
      // a request written while busy waits for the running one
      if (start_wr)
        start_pend_ff <= 1'b1;
      case (state_ff)
        S_IDLE: begin
          busy_ff <= 1'b0;
          if (start_pend_ff) begin
            start_pend_ff <= start_wr;
            work_ff <= eff_list;
            if (first_ch != `NO_CHAN) begin
              busy_ff <= 1'b1;
              cur_ff <= first_ch[`CH_W-1:0];
              gap_ff <= GAP_CYC;
              // first request since reset starts at once
              state_ff <= has_run_ff ? S_GAP : S_SEL;
              has_run_ff <= 1'b1;
            end
          end
        end
        S_GAP: begin
          gap_ff <= gap_ff - CNT_ONE;
          if (gap_ff == CNT_ONE)
            state_ff <= S_SEL;
        end
        S_SEL: begin
          slot_ff <= CNT_ONE;
          state_ff <= S_APPLY;
        end
        S_APPLY: begin
          // settings reach mux and amplifier before the convert pulse
          pos_sel_ff <= cur_ff;
          neg_sel_ff <= cfg_rd[`CFG_PAIRED_INPUT_MODE] && !cur_ff[`CH_W-1] ? cur_ff + `PAIR_OFS : `CH_ZERO;
          neg_to_ground_ff <= !(cfg_rd[`CFG_PAIRED_INPUT_MODE] && !cur_ff[`CH_W-1]);
          gain_sel_ff <= cfg_rd[`CFG_RANGE_HI:`CFG_RANGE_LO];
          res_range_ff <= cfg_rd[`CFG_RANGE_HI:`CFG_RANGE_LO];
          state_ff <= S_SETTLE;
        end
        S_SETTLE: begin
          if (slot_ff >= SETTLE_CYC) begin
            conv_start_ff <= 1'b1;
            state_ff <= S_CONV;
          end
        end
        S_CONV: begin
          if (adc_done) begin
            code_ff <= sat_code;
            res_clip_ff <= raw_hi | raw_lo;
            state_ff <= S_HOLD;
          end
        end
        S_HOLD: begin
          // a full buffer stretches the slot rather than dropping a result
          if (slot_end && fifo_in_ready) begin
            slot_ff <= {`CNT_W{1'b0}};
            if (nxt_ch == `NO_CHAN) begin
              state_ff <= S_IDLE;
            end else begin
              cur_ff <= nxt_ch[`CH_W-1:0];
              state_ff <= S_SEL;
            end
          end else if (slot_end) begin
            slot_ff <= slot_ff;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule

//--- design/analog_scan_defs.vh
// constants for the analog input scan controller
// assumes: included by bare name from every design file
`ifndef ANALOG_SCAN_DEFS_VH
`define ANALOG_SCAN_DEFS_VH
// register bus, word addresses
`define ADDR_W 6
`define DATA_W 32
`define REG_CTRL 6'h00
`define REG_SCAN_LIST 6'h01
`define REG_STATUS 6'h02
`define REG_RESULT 6'h03
`define REG_LSB 6'h04
`define CFG_PAGE 2'h1
// control and config fields
`define CTRL_START 0
`define CTRL_CLR_CLIP 1
`define CFG_W 3
`define CFG_RANGE_HI 1
`define CFG_RANGE_LO 0
`define CFG_PAIRED_INPUT_MODE 2
`define CFG_RST 3'h0
// status fields
`define STAT_BUSY 0
`define STAT_AVAIL 1
`define STAT_CLIP 2
`define STAT_CNT_LO 4
`define STAT_CNT_HI 7
// result word fields
`define RES_W 23
`define RES_CODE_HI 15
`define RES_CH_LO 16
`define RES_CH_HI 19
`define RES_RANGE_LO 20
`define RES_RANGE_HI 21
`define RES_CLIP 22
`define RES_VALID 31
// channels and codes
`define NUM_CH 16
`define CH_W 4
`define NUM_PAIRS 8
`define PAIR_OFS 4'h8
`define CH_ZERO 4'h0
`define NO_CHAN 5'h10
`define CODE_W 16
`define RAW_W 18
`define CODE_MAX 16'h7fff
`define CODE_MIN 16'h8000
// ranges and code step in microvolts, over-range included
`define RANGE_10V 2'h0
`define RANGE_5V 2'h1
`define RANGE_2V 2'h2
`define RANGE_1V 2'h3
`define LSB_10V_UV 16'h0140
`define LSB_5V_UV 16'h00a0
`define LSB_2V_UV 16'h0040
`define LSB_1V_UV 16'h0020
// timing in ns
`define CLK_NS 5
`define SCAN_NS 2000
`define GAP_NS 1000
`define SETTLE_NS 1000
`define CNT_W 12
// result buffer
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

//--- design/chan_cfg_mem.v
// per-channel range and terminal settings, one word per channel
// assumes: one write port from the bus, one registered read port
`include "analog_scan_defs.vh"
module chan_cfg_mem #(
  parameter WIDTH = `CFG_W,
  parameter DEPTH = `NUM_CH,
  parameter AW = `CH_W
) (
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data_ff
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  integer i;

  // reset to a known setting so a scan before any setup is defined
  always @(posedge clock) begin
    if (!nrst) begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_ff[i] <= `CFG_RST;
      rd_data_ff <= `CFG_RST;
    end else if (ce) begin
      if (wr_en)
        mem_ff[wr_addr] <= wr_data;
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule

//--- design/sample_fifo.v
// result buffer between the sequencer and the register bus
// assumes: single clock, ce freezes all state
`include "analog_scan_defs.vh"
module sample_fifo #(
  parameter WIDTH = `RES_W,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] count
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wptr_ff;
  reg [AW-1:0] rptr_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;

  // full and empty come from the occupancy count
  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data = mem_ff[rptr_ff];
  assign count = cnt_ff;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers wrap naturally only for power-of-two depth
  always @(posedge clock) begin
    if (!nrst) begin
      wptr_ff <= {AW{1'b0}};
      rptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem_ff[wptr_ff] <= in_data;
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop)
        rptr_ff <= rptr_ff + 1'b1;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule

//--- dv/analog_input_scan_control_asserts.sv
// port checks for the scan controller: pulses, legs, spacing
// assumes: bound to the top module, one clock, ce held high
`include "analog_scan_defs.vh"
module scan_ctrl_checker #(
  parameter CLK_NS = 5,
  parameter SCAN_NS = 2000
) (
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire [5:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rdata_ff,
  input wire [3:0] pos_sel_ff,
  input wire [3:0] neg_sel_ff,
  input wire neg_to_ground_ff,
  input wire [1:0] gain_sel_ff,
  input wire conv_start_ff,
  input wire busy_ff
);
  localparam int SCAN_CYC = SCAN_NS / CLK_NS;
  logic [15:0] list_ff;
  logic [11:0] since_ff;
  logic seen_ff;
  // shadow of the list, cycles since the last convert, saturating
  always @(posedge clock) begin
    if (!nrst) begin
      list_ff <= 16'h0;
      since_ff <= 12'h0;
      seen_ff <= 1'b0;
    end else if (ce) begin
      if (wr_en && addr == `REG_SCAN_LIST) list_ff <= wdata[15:0];
      since_ff <= conv_start_ff ? 12'h1 : since_ff + {11'h0, since_ff != 12'hfff};
      seen_ff <= busy_ff && (seen_ff || conv_start_ff);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_start_pulse: assert property (conv_start_ff |=> !conv_start_ff)
    else $error("convert request wider than one cycle");
  a_read_idle_zero: assert property (ce && !rd_en |=> rdata_ff == 32'h0)
    else $error("read data outside its cycle");
  a_start_runs: assert property (ce && wr_en && addr == `REG_CTRL && wdata[0] && !busy_ff && list_ff != 16'h0
    |-> ##[1:40] busy_ff)
    else $error("start request did not begin a scan");
  a_conv_in_scan: assert property (conv_start_ff |-> busy_ff)
    else $error("convert outside a scan");
  a_slot_spacing: assert property (conv_start_ff && seen_ff |-> since_ff >= SCAN_CYC)
    else $error("channels converted too close together");
  a_sel_settled: assert property (conv_start_ff |-> pos_sel_ff == $past(pos_sel_ff, 4)
    && gain_sel_ff == $past(gain_sel_ff, 4))
    else $error("settings changed just before convert");
  a_pair_legs: assert property (!neg_to_ground_ff |-> pos_sel_ff < 4'h8
    && neg_sel_ff == pos_sel_ff + 4'h8)
    else $error("paired legs wrong");
  a_single_leg: assert property (neg_to_ground_ff |-> neg_sel_ff == 4'h0)
    else $error("single input minus select not zero");
endmodule
bind analog_input_scan_control scan_ctrl_checker #(.CLK_NS(CLK_NS), .SCAN_NS(SCAN_NS)) chk_u (
  .clock(clock), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata_ff(rdata_ff), .pos_sel_ff(pos_sel_ff), .neg_sel_ff(neg_sel_ff), .neg_to_ground_ff(neg_to_ground_ff),
  .gain_sel_ff(gain_sel_ff), .conv_start_ff(conv_start_ff), .busy_ff(busy_ff));

//--- dv/adc_model.sv
// converter stand-in: one done pulse per convert request
// assumes: raw word per channel and answer delay set by the bench
module adc_model (
  input wire logic clock,
  input wire logic conv_start,
  input wire logic [3:0] pos_sel,
  input wire logic [3:0] slow,
  input wire logic [17:0] raw_tab [16],
  output logic adc_done,
  output logic [17:0] adc_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt = 4'h0;
  logic [17:0] hold = 18'h0;
  logic armed = 1'b0;
  initial adc_done = 1'b0;
  initial adc_raw = 18'h0;
  // raw word is valid only beside done; inverted otherwise so stale data never matches
  always @(posedge clock) begin
    adc_done <= 1'b0;
    adc_raw <= ~hold;
    if (conv_start) begin
      armed <= 1'b1;
      wait_cnt <= slow;
      hold <= raw_tab[pos_sel];
    end else if (armed) begin
      if (wait_cnt == 4'h0) begin
        adc_done <= 1'b1;
        adc_raw <= hold;
        armed <= 1'b0;
      end else wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule

//--- dv/analog_input_scan_control_tb_top.sv
// bench for the scan controller: register tasks, converter model, result checks
// assumes: shortened slot, gap and settle times passed to the design
`include "analog_scan_defs.vh"
module analog_input_scan_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SCAN_CYC = 20;
  localparam int GAP_CYC = 10;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [5:0] addr = 6'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] slow = 4'h0;
  logic [17:0] raw_tab [16];
  logic [15:0] lsb_tab [4] = '{`LSB_10V_UV, `LSB_5V_UV, `LSB_2V_UV, `LSB_1V_UV};
  wire [31:0] rdata_ff;
  wire [3:0] pos_sel_ff;
  wire [3:0] neg_sel_ff;
  wire [1:0] gain_sel_ff;
  wire neg_to_ground_ff;
  wire conv_start_ff;
  wire busy_ff;
  wire adc_done;
  wire [17:0] adc_raw;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_req = -1;
  int lat[$];
  int conv_t[$];
  logic [10:0] conv_log[$];
  logic [31:0] rd_val;
  always #2.5 clock = ~clock;
  analog_input_scan_control #(.CLK_NS(5), .SCAN_NS(100), .GAP_NS(50), .SETTLE_NS(40)) dut_u (
    .clock(clock), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata_ff(rdata_ff), .pos_sel_ff(pos_sel_ff), .neg_sel_ff(neg_sel_ff), .neg_to_ground_ff(neg_to_ground_ff),
    .gain_sel_ff(gain_sel_ff), .conv_start_ff(conv_start_ff), .adc_done(adc_done), .adc_raw(adc_raw),
    .busy_ff(busy_ff));
  adc_model conv_u (.clock(clock), .conv_start(conv_start_ff), .pos_sel(pos_sel_ff), .slow(slow),
    .raw_tab(raw_tab), .adc_done(adc_done), .adc_raw(adc_raw));
  // log conversions and the delay from a start request; cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (wr_en && addr == `REG_CTRL && wdata[0]) t_req <= cyc;
    if (conv_start_ff) begin
      conv_log.push_back({neg_to_ground_ff, neg_sel_ff, gain_sel_ff, pos_sel_ff});
      conv_t.push_back(cyc);
      if (t_req >= 0) lat.push_back(cyc - t_req);
      if (t_req >= 0) t_req <= -1;
    end
    // ceiling well above the thousand or fewer cycles the tests need
    if (cyc > 20000) begin
      error_cnt++;
      $display("mismatch at %0t: expected %h got %h", $time, 20000, cyc);
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  // read data stands in the cycle after the strobe only
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata_ff;
  endtask
  // busy rises as the gap starts on later requests and stays high through it
  task automatic wait_idle;
    int i;
    i = 0;
    while (busy_ff !== 1'b1 && i < 50) begin
      @(posedge clock);
      i++;
    end
    while (busy_ff !== 1'b0 && i < 4000) begin
      @(posedge clock);
      i++;
    end
    repeat (SCAN_CYC) @(posedge clock);
    chk(32'h0, {31'h0, busy_ff});
  endtask
  task automatic wait_avail;
    int i;
    i = 0;
    rd(`REG_STATUS, rd_val);
    while (rd_val[`STAT_AVAIL] !== 1'b1 && i < 100) begin
      rd(`REG_STATUS, rd_val);
      i++;
    end
    chk(32'h1, {31'h0, rd_val[`STAT_AVAIL]});
  endtask
  task automatic pop_chk(input logic [3:0] ch, input logic [1:0] rg, input logic clip, input logic [15:0] code);
    rd(`REG_RESULT, rd_val);
    chk({1'b1, 8'h0, clip, rg, ch, code}, rd_val);
    rd(`REG_LSB, rd_val);
    chk({16'h0, lsb_tab[rg]}, rd_val);
  endtask
  // main sequence
  initial begin
    logic [1:0] rg;
    for (int i = 0; i < 16; i++) raw_tab[i] = 18'(i * 257);
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rd(`REG_STATUS, rd_val);
    chk(32'h0, rd_val);
    rd(`REG_RESULT, rd_val);
    chk(32'h0, rd_val);
    rd(6'h3f, rd_val);
    chk(32'h0, rd_val);
    rd(6'h10, rd_val);
    chk(32'h0, rd_val);
    // mixed ranges, list given out of order, pair hides its minus input
    raw_tab[0] = 18'h64;
    raw_tab[3] = 18'h3_fffb;
    raw_tab[9] = 18'h1234;
    wr(6'h10, 32'h5);
    wr(6'h13, 32'h3);
    wr(6'h19, 32'h2);
    wr(`REG_SCAN_LIST, 32'h0309);
    rd(`REG_SCAN_LIST, rd_val);
    chk(32'h0309, rd_val);
    wr(`REG_CTRL, 32'h1);
    wait_idle();
    rd(`REG_STATUS, rd_val);
    chk(32'h32, rd_val);
    pop_chk(4'h0, 2'h1, 1'b0, 16'h64);
    pop_chk(4'h3, 2'h3, 1'b0, 16'hfffb);
    pop_chk(4'h9, 2'h2, 1'b0, 16'h1234);
    chk(32'h210, {21'h0, conv_log[0]});
    chk(32'h433, {21'h0, conv_log[1]});
    chk(32'h429, {21'h0, conv_log[2]});
    chk(32'(SCAN_CYC), 32'(conv_t[1] - conv_t[0]));
    chk(32'(SCAN_CYC), 32'(conv_t[2] - conv_t[1]));
    $display("test 1 done");
    // out of range both ways on a later request
    conv_t.delete();
    raw_tab[1] = 18'hffff;
    raw_tab[2] = 18'h2_0000;
    wr(`REG_SCAN_LIST, 32'h6);
    wr(`REG_CTRL, 32'h1);
    wait_idle();
    rd(`REG_STATUS, rd_val);
    chk(32'h26, rd_val);
    pop_chk(4'h1, 2'h0, 1'b1, 16'h7fff);
    pop_chk(4'h2, 2'h0, 1'b1, 16'h8000);
    wr(`REG_CTRL, 32'h2);
    rd(`REG_STATUS, rd_val);
    chk(32'h0, rd_val);
    chk(32'(GAP_CYC), 32'(lat[1] - lat[0]));
    chk(32'(SCAN_CYC), 32'(conv_t[1] - conv_t[0]));
    $display("test 2 done");
    // whole list with a slow converter: buffer fills and stalls, then drains
    for (int i = 0; i < 16; i++) raw_tab[i] = 18'(i * 257);
    slow <= 4'h9;
    wr(`REG_SCAN_LIST, 32'hffff);
    wr(`REG_CTRL, 32'h1);
    repeat (300) @(posedge clock);
    rd(`REG_STATUS, rd_val);
    chk(32'h83, rd_val);
    for (int c = 0; c < 16; c++) begin
      rg = (c == 0) ? 2'h1 : (c == 3) ? 2'h3 : (c == 9) ? 2'h2 : 2'h0;
      if (c != 8) wait_avail();
      if (c != 8) pop_chk(4'(c), rg, 1'b0, 16'(c * 257));
    end
    rd(`REG_RESULT, rd_val);
    chk(32'h0, rd_val);
    rd(`REG_STATUS, rd_val);
    chk(32'h0, rd_val);
    $display("test 3 done");
    report_and_stop();
  end
endmodule
